// [tcw_regs.vh]
// Constants for the transceiver configuration word bank.
// Assumes inclusion by the bank and its latch module only.
`ifndef TCW_REGS_VH
`define TCW_REGS_VH
`define TCW_WORD_W 24
`define TCW_ADDR_MSB 23
`define TCW_ADDR_LSB 21
`define TCW_ADDR_BANK0_FREQ 3'h0
`define TCW_ADDR_BANK1_FREQ 3'h1
`define TCW_ADDR_BANK1_CTRL 3'h2
`define TCW_ADDR_BANK0_CTRL 3'h3
`define TCW_ADDR_TEST 3'h7
`define TCW_WORD_RESET 24'h000000
`define TCW_FREQ_MSB 21
`define TCW_FREQ_W 22
`define TCW_FRONT_MSB 1
`define TCW_FRONT_LSB 0
`define TCW_MIXER_BIT 2
`define TCW_IF_BIT 3
`define TCW_LIMITER_BIT 4
`define TCW_RSSI_BIT 5
`define TCW_ROUTE_BIT 6
`define TCW_LOWPASS_BIT 7
`define TCW_SLICER_BIT 8
`define TCW_TXAMP_MSB 10
`define TCW_TXAMP_LSB 9
`define TCW_OSC_BIT 11
`define TCW_SYNTH_BIT 12
`define TCW_DEV_MSB 20
`define TCW_DEV_LSB 13
`define TCW_SLICER_MODE_BIT 15
`define TCW_MOD_SEL_BIT 16
`define TCW_DIVIDER_BIT 17
`define TCW_BOOST_MSB 20
`define TCW_BOOST_LSB 18
`define TCW_NUM_WORDS 4
`endif

// [tcw_word_latch.v]
// Four 24-bit configuration latches loaded from the shift register.
// Assumes one clk domain and a one-cycle load pulse with a word index.
`timescale 1ns/1ps
`default_nettype none
`include "tcw_regs.vh"
module tcw_word_latch (
  input wire clk,
  input wire rstn,
  input wire ce,
  input wire load,
  input wire [1:0] load_idx,
  input wire [23:0] load_data,
  output wire [95:0] words
);
  reg [23:0] word_q [0:3];
  genvar i;
  generate
    for (i = 0; i < `TCW_NUM_WORDS; i = i + 1) begin : g_word
      // Only the addressed word changes; others hold.
      always @(posedge clk) begin
        if (!rstn) begin
          word_q[i] <= `TCW_WORD_RESET;
        end else if (ce && load && (load_idx == i)) begin
          word_q[i] <= load_data;
        end
      end
      assign words[i*24 +: 24] = word_q[i];
    end
  endgenerate
endmodule // tcw_word_latch
`default_nettype wire

// [tcw_config_bank.v]
// Configuration word bank with three-wire serial loading.
// Assumes serial pins are asynchronous to clk and sampled here.
// How it works
// - Front amp field: 00,10 off; 01 low gain; 11 normal gain.
// - Mixer enable follows control bit 2.
// - Limiter follows bit 4, first IF amplifier follows bit 3.
// - Signal strength indicator enable follows bit 5.
// - Bit 6 routes lowpass input: 0 demodulator, 1 signal strength.
// - Bit 7 enables lowpass amplifier, bit 8 enables data slicer.
// - Transmit field: 00 off, 01 10 dB, 10 20 dB, 11 0 dB, modulation on.
// - Bit 12 enables the synthesizer; bit 11 enables the oscillator.
// - Demodulator on when limiter, lowpass on and route selects demodulator.
// - Bank0 frequency word holds 22-bit frequency, reset zero.
// - Bank1 frequency word holds 22-bit frequency, reset zero.
// - Bank0 control word bits 20:13 hold deviation, reset zero.
// - Bank1 control bit 15: slicer hold when 0, learning when 1.
// - Bank1 control bits 20:18 hold acquisition boost, reset zero.
// - Bank1 control bit 17: loop divider 256 when 0, 512 when 1.
// - Bank1 control bit 16 selects frequency-shift data; never write 1.
// - Words shift in MSB first on rising serial clock; keep last 24.
// - Strobe rising edge loads the addressed latch; data, clock low.
// - Mode pin selects which bank drives the radio.
`timescale 1ns/1ps
`default_nettype none
`include "tcw_regs.vh"
module tcw_config_bank (
  input wire clk,
  input wire rstn,
  input wire ce,
  input wire ser_clk,
  input wire ser_data,
  input wire ser_strobe,
  input wire mode_sel,
  output reg [1:0] front_amp_mode,
  output reg front_amp_enable,
  output reg front_amp_high_gain,
  output reg mixer_enable,
  output reg if_amp_enable,
  output reg limiter_enable,
  output reg signal_strength_enable,
  output reg baseband_route,
  output reg lowpass_amp_enable,
  output reg slicer_enable,
  output reg [1:0] tx_amp_level,
  output reg tx_amp_enable,
  output reg [1:0] tx_atten_sel,
  output reg tx_mod_enable,
  output reg oscillator_enable,
  output reg synth_enable,
  output reg demod_enable,
  output reg [21:0] freq_word,
  output reg [21:0] freq_word_bank0,
  output reg [21:0] freq_word_bank1,
  output reg [7:0] fsk_deviation,
  output reg slicer_hold_learn,
  output reg [2:0] acquisition_boost,
  output reg loop_divider_ratio,
  output reg modulation_select,
  output reg test_latch_hit
);
  localparam ST_IDLE = 1'b0;
  localparam ST_LOADED = 1'b1;

  // Maps a three-bit address onto a latch index; valid when a known word.
  function [2:0] addr_decode;
    input [2:0] addr;
    begin
      case (addr)
        `TCW_ADDR_BANK0_FREQ: addr_decode = 3'h4;
        `TCW_ADDR_BANK1_FREQ: addr_decode = 3'h5;
        `TCW_ADDR_BANK1_CTRL: addr_decode = 3'h6;
        `TCW_ADDR_BANK0_CTRL: addr_decode = 3'h7;
        default: addr_decode = 3'h0;
      endcase
    end
  endfunction

  // Three-stage samplers for the asynchronous pins.
  reg [2:0] sclk_q, sdat_q, sstb_q, mode_q;
  reg sclk_st_q, sstb_st_q, mode_st_q;
  reg [23:0] shift_q;
  reg state_q;
  reg load_q;
  reg [1:0] load_idx_q;
  reg [23:0] load_data_q;
  wire [95:0] words;
  wire [2:0] dec;
  wire sclk_rise;
  wire sstb_rise;
  wire [23:0] w_freq0, w_freq1, w_ctrl1, w_ctrl0, w_ctrl;
  wire [2:0] sclk_d, sdat_d, sstb_d, mode_d;

  assign sclk_d = {sclk_q[1:0], ser_clk};
  assign sdat_d = {sdat_q[1:0], ser_data};
  assign sstb_d = {sstb_q[1:0], ser_strobe};
  assign mode_d = {mode_q[1:0], mode_sel};

  always @(posedge clk) begin
    if (!rstn) begin
      sclk_q <= 3'h0;
      sdat_q <= 3'h0;
      sstb_q <= 3'h0;
      mode_q <= 3'h0;
    end else if (ce) begin
      sclk_q <= sclk_d;
      sdat_q <= sdat_d;
      sstb_q <= sstb_d;
      mode_q <= mode_d;
    end
  end

  // A pin counts as changed once stages two and three agree.
  always @(posedge clk) begin
    if (!rstn) begin
      sclk_st_q <= 1'b0;
      sstb_st_q <= 1'b0;
      mode_st_q <= 1'b0;
    end else if (ce) begin
      if (sclk_q[1] == sclk_q[2]) begin
        sclk_st_q <= sclk_q[2];
      end
      if (sstb_q[1] == sstb_q[2]) begin
        sstb_st_q <= sstb_q[2];
      end
      if (mode_q[1] == mode_q[2]) begin
        mode_st_q <= mode_q[2];
      end
    end
  end

  assign sclk_rise = (sclk_q[1] == sclk_q[2]) && sclk_q[2] && !sclk_st_q;
  assign sstb_rise = (sstb_q[1] == sstb_q[2]) && sstb_q[2] && !sstb_st_q;
  assign dec = addr_decode(shift_q[`TCW_ADDR_MSB:`TCW_ADDR_LSB]);

  // Shift MSB first; older leading bits fall off the top.
  always @(posedge clk) begin
    if (!rstn) begin
      shift_q <= `TCW_WORD_RESET;
    end else if (ce && sclk_rise && !sstb_st_q) begin
      shift_q <= {shift_q[22:0], sdat_q[2]};
    end
  end

  // Strobe rise hands the shifted word to the addressed latch.
  always @(posedge clk) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      load_q <= 1'b0;
      load_idx_q <= 2'h0;
      load_data_q <= `TCW_WORD_RESET;
      test_latch_hit <= 1'b0;
    end else if (ce) begin
      load_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (sstb_rise) begin
            state_q <= ST_LOADED;
            load_q <= dec[2];
            load_idx_q <= dec[1:0];
            load_data_q <= shift_q;
            if (shift_q[`TCW_ADDR_MSB:`TCW_ADDR_LSB] == `TCW_ADDR_TEST) begin
              test_latch_hit <= (shift_q[20:0] != 21'h000000);
            end
          end
        end
        ST_LOADED: begin
          if (!sstb_st_q) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  tcw_word_latch u_latch (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .load(load_q),
    .load_idx(load_idx_q),
    .load_data(load_data_q),
    .words(words)
  );

  assign w_freq0 = words[23:0];
  assign w_freq1 = words[47:24];
  assign w_ctrl1 = words[71:48];
  assign w_ctrl0 = words[95:72];
  // The mode pin picks the active bank of enables and frequency.
  assign w_ctrl = mode_st_q ? w_ctrl1 : w_ctrl0;

  always @(posedge clk) begin
    if (!rstn) begin
      front_amp_mode <= 2'h0;
      front_amp_enable <= 1'b0;
      front_amp_high_gain <= 1'b0;
      mixer_enable <= 1'b0;
      if_amp_enable <= 1'b0;
      limiter_enable <= 1'b0;
      signal_strength_enable <= 1'b0;
      baseband_route <= 1'b0;
      lowpass_amp_enable <= 1'b0;
      slicer_enable <= 1'b0;
      tx_amp_level <= 2'h0;
      tx_amp_enable <= 1'b0;
      tx_atten_sel <= 2'h0;
      tx_mod_enable <= 1'b0;
      oscillator_enable <= 1'b0;
      synth_enable <= 1'b0;
      demod_enable <= 1'b0;
      freq_word <= 22'h000000;
      freq_word_bank0 <= 22'h000000;
      freq_word_bank1 <= 22'h000000;
      fsk_deviation <= 8'h00;
      slicer_hold_learn <= 1'b0;
      acquisition_boost <= 3'h0;
      loop_divider_ratio <= 1'b0;
      modulation_select <= 1'b0;
    end else if (ce) begin
      front_amp_mode <= w_ctrl[`TCW_FRONT_MSB:`TCW_FRONT_LSB];
      // Only 01 and 11 power the front amp; bit 1 picks gain.
      front_amp_enable <= w_ctrl[`TCW_FRONT_LSB];
      front_amp_high_gain <= w_ctrl[`TCW_FRONT_LSB] & w_ctrl[`TCW_FRONT_MSB];
      mixer_enable <= w_ctrl[`TCW_MIXER_BIT];
      if_amp_enable <= w_ctrl[`TCW_IF_BIT];
      limiter_enable <= w_ctrl[`TCW_LIMITER_BIT];
      signal_strength_enable <= w_ctrl[`TCW_RSSI_BIT];
      baseband_route <= w_ctrl[`TCW_ROUTE_BIT];
      lowpass_amp_enable <= w_ctrl[`TCW_LOWPASS_BIT];
      slicer_enable <= w_ctrl[`TCW_SLICER_BIT];
      tx_amp_level <= w_ctrl[`TCW_TXAMP_MSB:`TCW_TXAMP_LSB];
      // Attenuation code: 0 for 0 dB, 1 for 10 dB, 2 for 20 dB.
      tx_amp_enable <= |w_ctrl[`TCW_TXAMP_MSB:`TCW_TXAMP_LSB];
      tx_mod_enable <= |w_ctrl[`TCW_TXAMP_MSB:`TCW_TXAMP_LSB];
      case (w_ctrl[`TCW_TXAMP_MSB:`TCW_TXAMP_LSB])
        2'h1: tx_atten_sel <= 2'h1;
        2'h2: tx_atten_sel <= 2'h2;
        default: tx_atten_sel <= 2'h0;
      endcase
      // The bit is passed through as written by the controller.
      oscillator_enable <= w_ctrl[`TCW_OSC_BIT];
      synth_enable <= w_ctrl[`TCW_SYNTH_BIT];
      // Demodulator follows limiter, lowpass and route.
      demod_enable <= w_ctrl[`TCW_LIMITER_BIT] & w_ctrl[`TCW_LOWPASS_BIT] &
                      ~w_ctrl[`TCW_ROUTE_BIT];
      freq_word_bank0 <= w_freq0[`TCW_FREQ_MSB:0];
      freq_word_bank1 <= w_freq1[`TCW_FREQ_MSB:0];
      freq_word <= mode_st_q ? w_freq1[`TCW_FREQ_MSB:0] :
                   w_freq0[`TCW_FREQ_MSB:0];
      fsk_deviation <= w_ctrl0[`TCW_DEV_MSB:`TCW_DEV_LSB];
      slicer_hold_learn <= w_ctrl1[`TCW_SLICER_MODE_BIT];
      acquisition_boost <= w_ctrl1[`TCW_BOOST_MSB:`TCW_BOOST_LSB];
      loop_divider_ratio <= w_ctrl1[`TCW_DIVIDER_BIT];
      modulation_select <= w_ctrl1[`TCW_MOD_SEL_BIT];
    end
  end
endmodule // tcw_config_bank
`default_nettype wire

// [tcw_chk.sv]
// Assertions on the configuration bank outputs.
// Assumes a bind to tcw_config_bank with one clock domain.
`timescale 1ns/1ps
`default_nettype none
module tcw_chk (
  input wire clk,
  input wire rstn,
  input wire ser_strobe,
  input wire mode_sel,
  input wire [1:0] front_amp_mode,
  input wire front_amp_enable,
  input wire front_amp_high_gain,
  input wire limiter_enable,
  input wire baseband_route,
  input wire lowpass_amp_enable,
  input wire [1:0] tx_amp_level,
  input wire tx_amp_enable,
  input wire [1:0] tx_atten_sel,
  input wire tx_mod_enable,
  input wire demod_enable,
  input wire [21:0] freq_word,
  input wire [21:0] freq_word_bank0,
  input wire [21:0] freq_word_bank1,
  input wire [7:0] fsk_deviation,
  input wire [2:0] acquisition_boost
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_front; front_amp_enable == front_amp_mode[0] &&
    front_amp_high_gain == &front_amp_mode; endproperty
  a_front: assert property (p_front) else $error("front amp decode");
  property p_txen; tx_amp_enable == |tx_amp_level &&
    tx_mod_enable == |tx_amp_level; endproperty
  a_txen: assert property (p_txen) else $error("tx enable decode");
  property p_atten; tx_atten_sel == ((tx_amp_level == 2'h1) ? 2'h1 :
    (tx_amp_level == 2'h2) ? 2'h2 : 2'h0); endproperty
  a_atten: assert property (p_atten) else $error("tx atten decode");
  property p_demod; demod_enable == (limiter_enable && lowpass_amp_enable &&
    !baseband_route); endproperty
  a_demod: assert property (p_demod) else $error("demod enable");
  property p_bank; (!ser_strobe && $stable(mode_sel))[*8] |->
    freq_word == (mode_sel ? freq_word_bank1 : freq_word_bank0); endproperty
  a_bank: assert property (p_bank) else $error("bank select");
  property p_hold; (!ser_strobe && $stable(mode_sel))[*8] |=>
    $stable({freq_word, front_amp_mode, tx_amp_level}); endproperty
  a_hold: assert property (p_hold) else $error("active word moved");
  property p_keep; (!ser_strobe)[*8] |=>
    $stable({fsk_deviation, acquisition_boost, freq_word_bank0}); endproperty
  a_keep: assert property (p_keep) else $error("bank word moved");
  property p_rst; $rose(rstn) |-> {freq_word_bank0, freq_word_bank1,
    fsk_deviation, acquisition_boost} == 0; endproperty
  a_rst: assert property (p_rst) else $error("reset value");
endmodule // tcw_chk
bind tcw_config_bank tcw_chk u_chk (.clk, .rstn, .ser_strobe, .mode_sel,
  .front_amp_mode, .front_amp_enable, .front_amp_high_gain, .limiter_enable,
  .baseband_route, .lowpass_amp_enable, .tx_amp_level, .tx_amp_enable,
  .tx_atten_sel, .tx_mod_enable, .demod_enable, .freq_word, .freq_word_bank0,
  .freq_word_bank1, .fsk_deviation, .acquisition_boost);
`default_nettype wire

// [tcw_mcu_model.sv]
// Controller model driving the three-wire programming bus.
// Assumes the bench clock; changes pins at its falling edge.
`timescale 1ns/1ps
`default_nettype none
module tcw_mcu_model (
  input wire logic clk,
  output logic ser_clk,
  output logic ser_data,
  output logic ser_strobe
);
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_strobe = 1'b0;
  end
  task automatic half();
    repeat (4) @(negedge clk);
  endtask
  task automatic send(input logic [23:0] w, input int extra);
    for (int i = 23 + extra; i >= 0; i--) begin
      ser_data = (i > 23) ? 1'b1 : w[i];
      half();
      ser_clk = 1'b1;
      half();
      ser_clk = 1'b0;
    end
    ser_data = 1'b0;
    half();
    ser_strobe = 1'b1;
    repeat (3) half();
    ser_strobe = 1'b0;
    half();
  endtask
endmodule // tcw_mcu_model
`default_nettype wire

// [transceiver_config_words_tb.sv]
// Self-checking bench for the configuration word bank.
// Assumes the controller model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module transceiver_config_words_tb;
  logic clk, rstn, ce, mode_sel, ser_clk, ser_data, ser_strobe;
  logic front_amp_enable, front_amp_high_gain, mixer_enable, if_amp_enable;
  logic limiter_enable, signal_strength_enable, baseband_route;
  logic lowpass_amp_enable, slicer_enable, tx_amp_enable, tx_mod_enable;
  logic oscillator_enable, synth_enable, demod_enable, slicer_hold_learn;
  logic loop_divider_ratio, modulation_select, test_latch_hit, tl;
  logic [1:0] front_amp_mode, tx_amp_level, tx_atten_sel;
  logic [21:0] freq_word, freq_word_bank0, freq_word_bank1;
  logic [7:0] fsk_deviation;
  logic [2:0] acquisition_boost;
  logic [23:0] w [8];
  logic [23:0] d;
  logic [31:0] seed;
  int fail_count, samples_checked, cyc;
  tcw_mcu_model i_mcu (.clk, .ser_clk, .ser_data, .ser_strobe);
  tcw_config_bank i_dut (.*);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [127:0] outs();
    return {front_amp_mode, front_amp_enable, front_amp_high_gain,
      slicer_enable, lowpass_amp_enable, baseband_route,
      signal_strength_enable, limiter_enable, if_amp_enable, mixer_enable,
      tx_amp_level, tx_amp_enable, tx_atten_sel, tx_mod_enable, synth_enable,
      oscillator_enable, demod_enable, freq_word, freq_word_bank0,
      freq_word_bank1, fsk_deviation, slicer_hold_learn, acquisition_boost,
      loop_divider_ratio, modulation_select, test_latch_hit};
  endfunction
  function automatic logic [127:0] expect_out(input logic m);
    logic [23:0] c;
    c = m ? w[2] : w[3];
    return {c[1:0], c[0], &c[1:0], c[8:2], c[10:9], |c[10:9],
      (c[10:9] == 2'h1) ? 2'h1 : (c[10:9] == 2'h2) ? 2'h2 : 2'h0,
      |c[10:9], c[12:11], c[4] & c[7] & !c[6], m ? w[1][21:0] : w[0][21:0],
      w[0][21:0], w[1][21:0], w[3][20:13], w[2][15], w[2][20:18], w[2][17],
      w[2][16], tl};
  endfunction
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic check_modes();
    for (int m = 0; m < 2; m++) begin
      @(negedge clk);
      mode_sel = m[0];
      repeat (8) @(negedge clk);
      check(outs(), expect_out(m[0]));
    end
  endtask
  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 15000) begin
      fail_count++;
      end_sim();
    end
  end
  initial begin
    ce = 1'b1;
    rstn = 1'b0;
    mode_sel = 1'b0;
    seed = 32'hBE2F;
    tl = 1'b0;
    foreach (w[i]) w[i] = 24'h000000;
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    check_modes();
    $display("reset test done");
    for (int n = 0; n < 24; n++) begin
      repeat (8) seed = lfsr(seed);
      case (n)
        0: d = 24'h5EFFFF;
        1: d = 24'h7FFFFF;
        2: d = 24'h3FFFFF;
        3: d = 24'h9FFFFF;
        4: d = 24'hE00001;
        default: d = seed[23:0];
      endcase
      if (d[23:22] == 2'h1) d[11] = 1'b1;
      if (d[23:21] == 3'h2) d[16] = 1'b0;
      i_mcu.send(d, n % 3);
      if (d[23] == 1'b0) w[d[23:21]] = d;
      if (d[23:21] == 3'h7) tl = |d[20:0];
      check_modes();
    end
    $display("random test done");
    end_sim();
  end
endmodule // transceiver_config_words_tb
`default_nettype wire
